// ===== design/packet_buffer_ports.sv
// pointer, packet number, allocation result and queue port logic of the packet memory
`timescale 1ns/100ps
`include "pbp_defines.svh"
module packet_buffer_ports #(
    parameter int PKT_W           = 6,
    parameter int QUEUE_DEPTH     = `PBP_QUEUE_DEPTH,
    parameter bit VARIANT_PRESENT = 1'b1
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [3:0]         bus_addr,
    input  wire logic               bus_rd,
    input  wire logic               bus_wr,
    input  wire logic [1:0]         bus_be,
    input  wire logic [15:0]        bus_wdata,
    output logic [15:0]             bus_rdata,
    input  wire logic               mmu_cmd_valid,
    input  wire logic [3:0]         mmu_cmd,
    input  wire logic               alloc_done,
    input  wire logic               alloc_fail,
    input  wire logic [PKT_W-1:0]   alloc_pkt,
    input  wire logic               rx_push,
    input  wire logic [PKT_W-1:0]   rx_pkt,
    output logic                    rx_push_ready,
    input  wire logic               done_push,
    input  wire logic [PKT_W-1:0]   done_pkt,
    output logic                    done_push_ready,
    input  wire logic               tx_int_ack,
    input  wire logic               underrun_variant_select,
    input  wire logic [7:0]         start_threshold,
    input  wire logic [10:0]        tx_dma_addr,
    input  wire logic [PKT_W-1:0]   tx_send_pkt,
    output logic [10:0]             mem_addr,
    output logic                    mem_receive_area,
    output logic [PKT_W-1:0]        mem_pkt,
    output logic                    access_read,
    output logic                    prefetch_start,
    output logic                    underrun_force,
    output logic                    auto_send_start
);
    initial begin
        if (PKT_W < 1 || PKT_W > 7)
            $error("packet_buffer_ports: packet number must fit below the flag bit");
        if (QUEUE_DEPTH < 2)
            $error("packet_buffer_ports: queue depth too small");
    end

    // ---------------------------------------------------------------- decode
    logic       wr_pnr;
    logic       wr_ptr;
    logic       data_acc;
    logic       cmd_mmu_rst;
    logic       cmd_rx_pop;
    logic       cmd_enqueue;
    logic       cmd_tx_rst;
    logic [1:0] inc_step;

    assign wr_pnr      = bus_wr && bus_addr == `PBP_OFF_PNR && bus_be[0];
    assign wr_ptr      = bus_wr && bus_addr == `PBP_OFF_PTR;
    assign data_acc    = (bus_wr || bus_rd) && bus_addr[3:2] == `PBP_DATA_SEL;
    assign cmd_mmu_rst = mmu_cmd_valid && mmu_cmd == `PBP_CMD_MMU_RST;
    assign cmd_rx_pop  = mmu_cmd_valid
                         && (mmu_cmd == `PBP_CMD_RX_POP || mmu_cmd == `PBP_CMD_RX_REL);
    assign cmd_enqueue = mmu_cmd_valid && mmu_cmd == `PBP_CMD_ENQUEUE;
    assign cmd_tx_rst  = mmu_cmd_valid && mmu_cmd == `PBP_CMD_TX_RST;
    assign inc_step    = (bus_be == 2'h3) ? 2'h2 : 2'h1;

    // ---------------------------------------------------------------- queues
    logic             rx_nonempty;
    logic [PKT_W-1:0] rx_top;
    logic             done_nonempty;
    logic [PKT_W-1:0] done_top;

    pkt_fifo #(
        .WIDTH (PKT_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_rx_queue (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (cmd_mmu_rst),
        .in_valid  (rx_push),
        .in_ready  (rx_push_ready),
        .in_data   (rx_pkt),
        .out_valid (rx_nonempty),
        .out_ready (cmd_rx_pop),
        .out_data  (rx_top)
    );

    // completion numbers leave on the transmit interrupt acknowledge, and an MMU reset or TX reset command flushes them
    pkt_fifo #(
        .WIDTH (PKT_W),
        .DEPTH (QUEUE_DEPTH)
    ) u_done_queue (
        .clk       (clk),
        .rst_n     (rst_n),
        .flush     (cmd_mmu_rst || cmd_tx_rst),
        .in_valid  (done_push),
        .in_ready  (done_push_ready),
        .in_data   (done_pkt),
        .out_valid (done_nonempty),
        .out_ready (tx_int_ack),
        .out_data  (done_top)
    );

    // ------------------------------------------- packet number and allocation
    logic [PKT_W-1:0] pnr_q;
    logic [PKT_W-1:0] pnr_d;
    logic [PKT_W-1:0] arr_pkt_q;
    logic             failed_q;
    logic             failed_d;

    assign pnr_d = cmd_mmu_rst ? '0 : wr_pnr ? bus_wdata[PKT_W-1:0] : pnr_q;
    // an MMU reset forces failure, and a reported failure beats a success
    assign failed_d = (cmd_mmu_rst || (alloc_done && alloc_fail)) ? 1'b1
                    : (alloc_done && !alloc_fail) ? 1'b0
                    : failed_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pnr_q     <= '0;
            arr_pkt_q <= '0;
            failed_q  <= 1'b1;
        end else begin
            pnr_q    <= pnr_d;
            failed_q <= failed_d;
            if (alloc_done) begin
                arr_pkt_q <= alloc_pkt;
            end
        end
    end

    // ---------------------------------------------------------------- pointer
    logic [15:0]          ptr_q;
    logic [15:0]          ptr_wr;
    logic [15:0]          ptr_d;
    pbp_pkg::buf_addr_t   ptr_addr;
    pbp_pkg::buf_addr_t   ptr_inc;
    logic                 ptr_loaded;
    logic                 sel_rcv;
    logic                 sel_ainc;
    logic                 sel_read;
    logic                 sel_early;
    logic                 sel_auto;

    assign ptr_addr  = ptr_q[`PBP_ADDR_W-1:0];
    assign sel_rcv   = ptr_q[`PBP_PTR_RCV];
    assign sel_ainc  = ptr_q[`PBP_PTR_AINC];
    assign sel_read  = ptr_q[`PBP_PTR_READ];
    assign sel_early = ptr_q[`PBP_PTR_EARLY];
    assign sel_auto  = ptr_q[`PBP_PTR_AUTO];
    assign ptr_wr    = {bus_be[1] ? bus_wdata[15:8] : ptr_q[15:8],
                        bus_be[0] ? bus_wdata[7:0] : ptr_q[7:0]};
    assign ptr_inc   = ptr_addr + pbp_pkg::buf_addr_t'(inc_step);
    // a load is complete when the high byte lands, so byte loads go low then high
    assign ptr_loaded = wr_ptr && bus_be[1];

    // the pointer only moves on host accesses, so it reads back the address
    // the next host access will use, even while a prefetch runs ahead
    always_comb begin
        ptr_d = ptr_q;
        if (wr_ptr) begin
            ptr_d = ptr_wr;
        end else if (data_acc && sel_ainc) begin
            ptr_d = {ptr_q[15:`PBP_ADDR_W], ptr_inc};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ptr_q <= `PBP_PTR_RESET;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // -------------------------------------------------- memory side outputs
    logic [PKT_W-1:0] area_pkt;
    logic             area_rcv;
    // area and packet follow the next pointer so they never lag mem_addr
    assign area_rcv = ptr_d[`PBP_PTR_RCV];
    assign area_pkt = area_rcv ? rx_top : pnr_d;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_addr         <= '0;
            mem_receive_area <= 1'b0;
            mem_pkt          <= '0;
            access_read      <= 1'b0;
            prefetch_start   <= 1'b0;
        end else begin
            mem_addr         <= ptr_d[`PBP_ADDR_W-1:0];
            mem_receive_area <= area_rcv;
            mem_pkt          <= area_pkt;
            access_read      <= ptr_d[`PBP_PTR_READ];
            prefetch_start   <= ptr_loaded && ptr_wr[`PBP_PTR_READ];
        end
    end

    // -------------------------------------------------------- early sending
    pbp_pkg::underrun_mode_e mode;
    logic                    send_ahead;
    logic                    pkt_match;
    logic                    starve;

    // a part without the variant bit behaves as the pointer compare
    assign mode = (VARIANT_PRESENT && underrun_variant_select)
                  ? pbp_pkg::UNDERRUN_MATCH : pbp_pkg::UNDERRUN_POINTER;
    assign send_ahead = tx_dma_addr > ptr_addr;
    assign pkt_match  = tx_send_pkt == pnr_q;
    assign starve = sel_early && send_ahead
                    && (mode == pbp_pkg::UNDERRUN_POINTER || pkt_match);

    // ------------------------------------------------------------ auto send
    logic        armed_q;
    logic        auto_on;
    logic [11:0] thresh_bytes;
    logic        reached;

    assign auto_on      = sel_auto && sel_early && !sel_rcv
                          && start_threshold != 8'h00;
    assign thresh_bytes = {start_threshold, 4'h0} >> (`PBP_THRESH_SHIFT - 4);
    assign reached      = {1'b0, ptr_addr} >= thresh_bytes;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_q         <= 1'b0;
            auto_send_start <= 1'b0;
            underrun_force  <= 1'b0;
        end else begin
            underrun_force  <= starve;
            auto_send_start <= armed_q && auto_on && reached;
            if (cmd_enqueue) begin
                armed_q <= 1'b1;
            end else if (cmd_mmu_rst || cmd_tx_rst || (armed_q && auto_on && reached)) begin
                armed_q <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------- register read
    logic [15:0] rd_mux;
    logic [7:0]  rx_byte;
    logic [7:0]  done_byte;
    logic [7:0]  arr_byte;
    logic [7:0]  pnr_byte;

    assign rx_byte   = {!rx_nonempty, (7-PKT_W)'(0), rx_top};
    assign done_byte = {!done_nonempty, (7-PKT_W)'(0), done_top};
    assign arr_byte  = {failed_q, (7-PKT_W)'(0), arr_pkt_q};
    assign pnr_byte  = {(8-PKT_W)'(0), pnr_q};
    assign rd_mux    = (bus_addr == `PBP_OFF_QUEUE) ? {rx_byte, done_byte}
                     : (bus_addr == `PBP_OFF_PTR)   ? ptr_q
                     : (bus_addr == `PBP_OFF_PNR)   ? {arr_byte, pnr_byte}
                     : 16'h0000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_rdata <= 16'h0000;
        end else if (bus_rd) begin
            bus_rdata <= rd_mux;
        end
    end
endmodule

// ===== design/pbp_defines.svh
// constants for the packet buffer pointer and queue port block
`ifndef PBP_DEFINES_SVH
`define PBP_DEFINES_SVH

`define PBP_OFF_PNR      4'h2
`define PBP_OFF_QUEUE    4'h4
`define PBP_OFF_PTR      4'h6
`define PBP_DATA_SEL     2'h2
`define PBP_PTR_RCV      15
`define PBP_PTR_AINC     14
`define PBP_PTR_READ     13
`define PBP_PTR_EARLY    12
`define PBP_PTR_AUTO     11
`define PBP_ADDR_W       11
`define PBP_PTR_RESET    16'h0000
`define PBP_EMPTY_BIT    7
`define PBP_FAIL_BIT     7
`define PBP_THRESH_SHIFT 4
`define PBP_CMD_MMU_RST  4'h4
`define PBP_CMD_RX_POP   4'h6
`define PBP_CMD_RX_REL   4'h8
`define PBP_CMD_ENQUEUE  4'hC
`define PBP_CMD_TX_RST   4'hE
`define PBP_QUEUE_DEPTH  32

`endif

// ===== design/pbp_pkg.sv
// types shared by the packet buffer pointer block
package pbp_pkg;
    typedef logic [10:0] buf_addr_t;
    typedef enum logic {UNDERRUN_POINTER, UNDERRUN_MATCH} underrun_mode_e;
endpackage

// ===== design/pkt_fifo.sv
// packet number queue with registered flags
`timescale 1ns/100ps
module pkt_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("pkt_fifo: depth must be a power of two and width positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    // an empty queue shows zero, never a stale or unwritten entry
    assign out_data = out_valid ? mem[rd_q] : '0;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // flags are registered so the top can hand them out as flop outputs
    always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
            wr_q      <= '0;
            rd_q      <= '0;
            cnt_q     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_q      <= wr_q + AW'(push);
            rd_q      <= rd_q + AW'(pop);
            cnt_q     <= cnt_d;
            in_ready  <= (cnt_d != (AW+1)'(DEPTH));
            out_valid <= (cnt_d != '0);
        end
    end
endmodule

// ===== tb/packet_buffer_ports_checker.sv
// port-level assertions for the packet buffer pointer block
`timescale 1ns/100ps
module packet_buffer_ports_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  bus_addr,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic [1:0]  bus_be,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic        rx_push,
    input wire logic        rx_push_ready,
    input wire logic [7:0]  start_threshold,
    input wire logic [10:0] tx_dma_addr,
    input wire logic [10:0] mem_addr,
    input wire logic        mem_receive_area,
    input wire logic        access_read,
    input wire logic        prefetch_start,
    input wire logic        underrun_force,
    input wire logic        auto_send_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic ptr_word;
    logic ptr_high;
    assign ptr_word = bus_wr && bus_addr == 4'h6 && bus_be == 2'h3;
    assign ptr_high = bus_wr && bus_addr == 4'h6 && bus_be[1];
    a_prefetch_on_load: assert property (ptr_word && bus_wdata[13] |=> prefetch_start)
        else $error("no prefetch after pointer load with read bit");
    a_prefetch_no_load: assert property (!ptr_high |=> !prefetch_start)
        else $error("prefetch without pointer load");
    a_area_follows: assert property (ptr_word |=> mem_receive_area == $past(bus_wdata[15]))
        else $error("area select does not follow pointer");
    a_addr_follows: assert property (ptr_word |=> mem_addr == $past(bus_wdata[10:0]))
        else $error("memory address does not follow pointer");
    a_dir_follows: assert property (ptr_word |=> access_read == $past(bus_wdata[13]))
        else $error("direction does not follow pointer");
    a_rdata_stands: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without read");
    a_auto_one_shot: assert property (auto_send_start |=> !auto_send_start)
        else $error("auto send start longer than one cycle");
    a_auto_threshold: assert property (auto_send_start |-> $past(start_threshold) != 8'h00)
        else $error("auto send with zero threshold");
    a_ready_by_push: assert property ($fell(rx_push_ready) |-> $past(rx_push))
        else $error("queue ready fell without push");
    a_underrun_cause: assert property ($rose(underrun_force) |-> $past(tx_dma_addr) > $past(mem_addr))
        else $error("underrun without dma passing pointer");
endmodule
bind packet_buffer_ports packet_buffer_ports_checker chk (
    .clk(clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .rx_push(rx_push),
    .rx_push_ready(rx_push_ready), .start_threshold(start_threshold),
    .tx_dma_addr(tx_dma_addr), .mem_addr(mem_addr), .mem_receive_area(mem_receive_area),
    .access_read(access_read), .prefetch_start(prefetch_start),
    .underrun_force(underrun_force), .auto_send_start(auto_send_start));

// ===== tb/host_bus_model.sv
// host processor side of the local register bus
`timescale 1ns/100ps
module host_bus_model (
    input wire logic        clk,
    output logic [3:0]      bus_addr,
    output logic            bus_rd,
    output logic            bus_wr,
    output logic [1:0]      bus_be,
    output logic [15:0]     bus_wdata,
    input wire logic [15:0] bus_rdata
);
    initial begin
        bus_addr = 4'h0;
        bus_rd = 1'b0;
        bus_wr = 1'b0;
        bus_be = 2'h0;
        bus_wdata = 16'h0000;
    end
    // strobes drop for a cycle between accesses so no signal is set twice in a step
    task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_be = be;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
        bus_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_be = 2'h3;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        d = bus_rdata;
    endtask
endmodule

// ===== tb/packet_buffer_ports_test.sv
// self-checking bench for the packet buffer pointer block
`timescale 1ns/100ps
module packet_buffer_ports_test;
    logic clk, rst_n, cmd_v, a_done, a_fail, rx_push, rx_rdy, d_push, d_rdy, ack, vsel;
    logic [3:0] addr, cmd;
    logic rd, wr, area, dir, pre, und, ast;
    logic [1:0] be;
    logic [15:0] wd, rdat, d;
    logic [5:0] a_pkt, rx_pkt, d_pkt, s_pkt, m_pkt;
    logic [7:0] thr;
    logic [10:0] dma, maddr;
    int error_cnt, compares, cyc, seen;
    logic [26:0] rows [3] = '{{16'h2004, 11'h004}, {16'hC7FE, 11'h7FE}, {16'h0312, 11'h312}};
    packet_buffer_ports uut (.clk(clk), .rst_n(rst_n), .bus_addr(addr), .bus_rd(rd),
        .bus_wr(wr), .bus_be(be), .bus_wdata(wd), .bus_rdata(rdat), .mmu_cmd_valid(cmd_v),
        .mmu_cmd(cmd), .alloc_done(a_done), .alloc_fail(a_fail), .alloc_pkt(a_pkt),
        .rx_push(rx_push), .rx_pkt(rx_pkt), .rx_push_ready(rx_rdy), .done_push(d_push),
        .done_pkt(d_pkt), .done_push_ready(d_rdy), .tx_int_ack(ack),
        .underrun_variant_select(vsel), .start_threshold(thr), .tx_dma_addr(dma),
        .tx_send_pkt(s_pkt), .mem_addr(maddr), .mem_receive_area(area), .mem_pkt(m_pkt),
        .access_read(dir), .prefetch_start(pre), .underrun_force(und), .auto_send_start(ast));
    host_bus_model host (.clk(clk), .bus_addr(addr), .bus_rd(rd), .bus_wr(wr), .bus_be(be),
        .bus_wdata(wd), .bus_rdata(rdat));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic stop_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0, g}, {15'h0, e});
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        host.rd(a, d);
        chk16(d, e);
    endtask
    // side inputs change only at the falling edge
    task automatic pulse(input int which, input logic [3:0] c);
        @(negedge clk);
        cmd = c;
        if (which == 0) cmd_v = 1'b1;
        else ack = 1'b1;
        @(negedge clk);
        cmd_v = 1'b0;
        ack = 1'b0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        {rst_n, cmd_v, a_done, a_fail, rx_push, d_push, ack, vsel} = 8'h00;
        {cmd, a_pkt, rx_pkt, d_pkt, s_pkt, thr, dma} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rc(4'h4, 16'h8080);
        rc(4'h6, 16'h0000);
        rc(4'h2, 16'h8000);
        foreach (rows[i]) begin
            host.wr(4'h6, 2'h3, rows[i][26:11]);
            chk16({5'h0, maddr}, {5'h0, rows[i][10:0]});
            rc(4'h6, rows[i][26:11]);
        end
        host.wr(4'h6, 2'h3, 16'h6020);
        chk1(pre, 1'b1);
        chk1(dir, 1'b1);
        repeat (40) @(negedge clk);
        host.rd(4'h8, d);
        rc(4'h6, 16'h6022);
        host.wr(4'h6, 2'h1, 16'h0010);
        host.wr(4'h6, 2'h2, 16'h4000);
        host.wr(4'h8, 2'h3, 16'h1234);
        rc(4'h6, 16'h4012);
        host.wr(4'hA, 2'h1, 16'h0056);
        rc(4'h6, 16'h4013);
        chk16({5'h0, maddr}, 16'h0013);
        @(negedge clk);
        {rx_push, rx_pkt, d_push, d_pkt} = {1'b1, 6'h05, 1'b1, 6'h09};
        @(negedge clk);
        {rx_push, d_push} = 2'b00;
        rc(4'h4, 16'h0509);
        repeat (40) @(negedge clk);
        host.wr(4'h6, 2'h3, 16'h8000);
        chk16({10'h0, m_pkt}, 16'h0005);
        chk1(area, 1'b1);
        pulse(0, 4'h6);
        host.rd(4'h4, d);
        chk16(d, 16'h8009);
        pulse(1, 4'h0);
        host.rd(4'h4, d);
        chk16(d, 16'h8080);
        @(negedge clk);
        {a_done, a_fail, a_pkt} = {2'b10, 6'h03};
        @(negedge clk);
        a_done = 1'b0;
        rc(4'h2, 16'h0300);
        host.wr(4'h2, 2'h1, 16'h0003);
        rc(4'h2, 16'h0303);
        @(negedge clk);
        rx_push = 1'b1;
        repeat (40) @(negedge clk);
        rx_push = 1'b0;
        chk1(rx_rdy, 1'b0);
        chk1(d_rdy, 1'b1);
        pulse(0, 4'h8);
        @(negedge clk);
        chk1(rx_rdy, 1'b1);
        pulse(0, 4'h4);
        rc(4'h2, 16'h8300);
        host.wr(4'h6, 2'h3, 16'h1010);
        dma = 11'h020;
        repeat (3) @(negedge clk);
        chk1(und, 1'b1);
        vsel = 1'b1;
        s_pkt = 6'h01;
        repeat (3) @(negedge clk);
        chk1(und, 1'b0);
        s_pkt = 6'h00;
        repeat (3) @(negedge clk);
        chk1(und, 1'b1);
        {vsel, dma} = '0;
        pulse(0, 4'hC);
        host.wr(4'h6, 2'h3, 16'h1840);
        seen = 0;
        repeat (6) @(negedge clk) seen += ast;
        chk16(seen[15:0], 16'h0000);
        thr = 8'h04;
        repeat (6) @(negedge clk) seen += ast;
        chk16(seen[15:0], 16'h0001);
        host.wr(4'h2, 2'h1, 16'h0007);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        rc(4'h4, 16'h8080);
        rc(4'h6, 16'h0000);
        rc(4'h2, 16'h8000);
        stop_test();
    end
endmodule
